// ### pkg/spal_pkg.sv
// Shared constants, opcode decoding and helpers for the serial programming link.
// Used by the device end and the programmer end; no clocked logic here.
package spal_pkg;
    // Character framing: receive bits counted after the start bit, transmit bits including it; operand counts
    localparam logic [3:0] RX_LAST = 4'ha;
    localparam logic [3:0] TX_BITS = 4'hc;
    localparam logic [3:0] KEY_BYTES = 4'h8;
    localparam logic [3:0] ONE_OPERAND = 4'h1;
    // Fixed opcodes
    localparam logic [7:0] OPC_LD = 8'h20;
    localparam logic [7:0] OPC_LDI = 8'h24;
    localparam logic [7:0] OPC_ST = 8'h60;
    localparam logic [7:0] OPC_STI = 8'h64;
    localparam logic [7:0] OPC_KEY = 8'he0;
    // Control/status space
    localparam logic [3:0] CSS_STATUS = 4'h0;
    localparam logic [3:0] CSS_PHYCTL = 4'h2;
    localparam logic [3:0] CSS_IDENT = 4'hf;
    localparam int unsigned NVM_BIT = 1;
    localparam logic [2:0] GT_RESET = 3'h0;
    localparam logic [2:0] GT_NONE = 3'h7;
    localparam logic [8:0] GT_MAX = 9'h080;
    localparam logic [8:0] IDLE_EXTRA = 9'h002;
    localparam logic [15:0] PTR_RESET = 16'h0000;

    typedef enum {
        OP_LD, OP_LDI, OP_ST, OP_STI, OP_STPTR, OP_IN, OP_OUT,
        OP_LDCS, OP_STCS, OP_KEY, OP_BAD
    } spal_op_e;

    function automatic spal_op_e spal_decode(input logic [7:0] op);
        spal_op_e r;
        r = OP_BAD;
        casez (op)
            OPC_LD: r = OP_LD;
            OPC_LDI: r = OP_LDI;
            OPC_ST: r = OP_ST;
            OPC_STI: r = OP_STI;
            OPC_KEY: r = OP_KEY;
            8'b0110_100?: r = OP_STPTR;
            8'b0??1_????: r = OP_IN;
            8'b1??1_????: r = OP_OUT;
            8'b1000_????: r = OP_LDCS;
            8'b1100_????: r = OP_STCS;
            default: r = OP_BAD;
        endcase
        return r;
    endfunction

    // Even parity over the data bits
    function automatic logic spal_parity(input logic [7:0] d);
        return ^d;
    endfunction

    // Six-bit direct address spread over opcode bits 6:5 and 3:0
    function automatic logic [15:0] spal_io_addr(input logic [7:0] op);
        return {10'h000, op[6:5], op[3:0]};
    endfunction

    // Extra idle bits for each guard-time code
    function automatic logic [8:0] spal_guard(input logic [2:0] gt);
        return (gt == GT_NONE) ? 9'h000 : (GT_MAX >> gt);
    endfunction
endpackage

// ### pkg/spal_link_if.sv
// Two-wire programming link: clock made by the programmer, one shared data line.
// The data line has a pull-up; either end pulls it by its enable.
`timescale 1ns/1ps
interface spal_link_if;
    logic link_clk;
    logic host_o;
    logic host_oe;
    logic dev_o;
    logic dev_oe;
    logic line;

    // Wired level: low if any enabled driver sends a zero
    assign line = ~((host_oe & ~host_o) | (dev_oe & ~dev_o));

    modport host (output link_clk, output host_o, output host_oe, input line);
    modport device (input link_clk, input line, output dev_o, output dev_oe);
endinterface

// ### logic/spal_device.sv
// Device end of the serial programming link: character layer and instruction decoder.
// Assumes the programmer drives the link clock and a data space answers reads in the read strobe cycle.
// Functional notes
// - Instruction byte first, then byte operands
// - Programmer sends all bytes of write messages
// - Read instructions answered with one byte
// - One operand; key takes eight
// - Access layer switches receive and transmit
// - Parity, frame, break, collision enter error
// - Error state left only by break
// - Break enters error, or leaves it for idle
// - Indirect load, optional pointer increment
// - Indirect store, optional pointer increment
// - Pointer byte store, bit 0 selects
// - I/O read at six-bit address
// - I/O write at six-bit address
// - Control space read, four-bit address
// - Control space write, four-bit address
// - Eight key bytes unlock programming
// - Pointer loaded before indirect access
// - Start, eight data LSB first, parity, two stops
// - Break is twelve or more low bits
// - Guard plus two idle bits before reply
// - Change on falling, sample on rising
`timescale 1ns/1ps
module spal_device #(
    // Identity value is arbitrary
    parameter logic [7:0] IDENT = 8'h5a,
    parameter logic [63:0] UNLOCK_KEY = 64'h0123_4567_89ab_cdef
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link
    spal_link_if.device lnk,
    // Data and I/O space access
    output logic acc_rd,
    output logic acc_wr,
    output logic acc_io,
    output logic [15:0] acc_addr,
    output logic [7:0] acc_wdata,
    input wire logic [7:0] acc_rdata,
    // Status
    output logic nvm_enable
);
    import spal_pkg::*;

    typedef enum {S_IDLE, S_OPER, S_RDWAIT, S_SEND, S_ERR} spal_st_e;

    logic [1:0] clk_s_r;
    logic [1:0] dat_s_r;
    logic clk_d_r;
    logic rise;
    logic fall;
    logic din;
    logic rx_busy_r;
    logic rx_hold_r;
    logic [3:0] rx_cnt_r;
    logic [10:0] rx_sh_r;
    logic [10:0] rx_full;
    logic rx_byte_p_r;
    logic rx_brk_p_r;
    logic rx_err_p_r;
    logic tx_act_r;
    logic tx_out_r;
    logic tx_oe_r;
    logic tx_last_r;
    logic tx_done_p_r;
    logic tx_coll_p_r;
    logic [8:0] tx_idle_r;
    logic [3:0] tx_bit_r;
    logic [11:0] tx_frm_r;
    logic tx_go_r;
    logic [7:0] tx_dat_r;
    spal_st_e st_r;
    logic [7:0] op_r;
    logic [3:0] left_r;
    logic [15:0] ptr_r;
    logic [2:0] gt_r;
    logic nvm_r;
    logic [63:0] key_r;
    logic [63:0] key_nxt;
    logic exc;
    logic take_op;
    logic take_opnd;
    logic [7:0] rx_dat;
    logic [7:0] css_q;
    spal_op_e new_op;
    spal_op_e cur_op;

    // Link clock and data pass two flops before use
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            clk_s_r <= 2'h0;
            dat_s_r <= 2'h3;
            clk_d_r <= 1'b0;
        end
        else
        begin
            clk_s_r <= {clk_s_r[0], lnk.link_clk};
            dat_s_r <= {dat_s_r[0], lnk.line};
            clk_d_r <= clk_s_r[1];
        end
    end

    assign rise = clk_s_r[1] & ~clk_d_r;
    assign fall = ~clk_s_r[1] & clk_d_r;
    assign din = dat_s_r[1];
    assign rx_full = {din, rx_sh_r[10:1]};
    assign rx_dat = rx_sh_r[7:0];

    // Receiver, idle while transmitting
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rx_busy_r <= 1'b0;
            rx_hold_r <= 1'b0;
            rx_cnt_r <= 4'h0;
            rx_sh_r <= 11'h000;
            rx_byte_p_r <= 1'b0;
            rx_brk_p_r <= 1'b0;
            rx_err_p_r <= 1'b0;
        end
        else
        begin
            rx_byte_p_r <= 1'b0;
            rx_brk_p_r <= 1'b0;
            rx_err_p_r <= 1'b0;
            if (rise && !tx_act_r)
            begin
                // Long break: wait for high line
                if (rx_hold_r)
                    rx_hold_r <= ~din;
                else if (!rx_busy_r)
                begin
                    rx_busy_r <= ~din;
                    rx_cnt_r <= 4'h0;
                end
                else
                begin
                    rx_sh_r <= rx_full;
                    rx_cnt_r <= rx_cnt_r + 4'h1;
                    if (rx_cnt_r == RX_LAST)
                    begin
                        rx_busy_r <= 1'b0;
                        if (rx_full == 11'h000)
                        begin
                            rx_brk_p_r <= 1'b1;
                            rx_hold_r <= 1'b1;
                        end
                        else if (rx_full[10:9] != 2'b11)
                            rx_err_p_r <= 1'b1;
                        else if (spal_parity(rx_full[7:0]) != rx_full[8])
                            rx_err_p_r <= 1'b1;
                        else
                            rx_byte_p_r <= 1'b1;
                    end
                end
            end
        end
    end

    // Transmitter with guard time and collision watch
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            tx_act_r <= 1'b0;
            tx_out_r <= 1'b1;
            tx_oe_r <= 1'b0;
            tx_last_r <= 1'b1;
            tx_done_p_r <= 1'b0;
            tx_coll_p_r <= 1'b0;
            tx_idle_r <= 9'h000;
            tx_bit_r <= 4'h0;
            tx_frm_r <= 12'hfff;
        end
        else
        begin
            tx_done_p_r <= 1'b0;
            tx_coll_p_r <= 1'b0;
            if (tx_go_r)
            begin
                // Guard time plus two idle bits
                tx_act_r <= 1'b1;
                tx_idle_r <= spal_guard(gt_r) + IDLE_EXTRA;
                tx_bit_r <= 4'h0;
                tx_frm_r <= {2'b11, spal_parity(tx_dat_r), tx_dat_r, 1'b0};
                tx_last_r <= 1'b1;
            end
            else if (tx_act_r)
            begin
                if (rise && !tx_oe_r && !din && tx_bit_r != 4'h0)
                begin
                    tx_coll_p_r <= 1'b1;
                    tx_act_r <= 1'b0;
                    tx_out_r <= 1'b1;
                end
                else if (fall)
                begin
                    if (tx_idle_r != 9'h000)
                        tx_idle_r <= tx_idle_r - 9'h001;
                    else if (tx_bit_r != TX_BITS)
                    begin
                        // Drive zeros, and the first one after a zero
                        tx_out_r <= tx_frm_r[0];
                        tx_oe_r <= ~tx_frm_r[0] | ~tx_last_r;
                        tx_last_r <= tx_frm_r[0];
                        tx_frm_r <= {1'b1, tx_frm_r[11:1]};
                        tx_bit_r <= tx_bit_r + 4'h1;
                    end
                    else
                    begin
                        tx_act_r <= 1'b0;
                        tx_oe_r <= 1'b0;
                        tx_out_r <= 1'b1;
                        tx_done_p_r <= 1'b1;
                    end
                end
            end
            if (tx_coll_p_r || (rise && !tx_oe_r && !din && tx_act_r && tx_bit_r != 4'h0))
                tx_oe_r <= 1'b0;
        end
    end

    assign lnk.dev_o = tx_out_r;
    assign lnk.dev_oe = tx_oe_r;

    assign exc = rx_brk_p_r | rx_err_p_r | tx_coll_p_r;
    assign new_op = spal_decode(rx_dat);
    assign cur_op = spal_decode(op_r);
    assign take_op = (st_r == S_IDLE) && rx_byte_p_r && !exc;
    assign take_opnd = (st_r == S_OPER) && rx_byte_p_r && !exc;

    // Message sequencing
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            st_r <= S_IDLE;
        else
        begin
            case (st_r)
                S_IDLE:
                    if (exc)
                        st_r <= S_ERR;
                    else if (rx_byte_p_r)
                    begin
                        // Read types turn the line round
                        case (new_op)
                            OP_LD, OP_LDI, OP_IN: st_r <= S_RDWAIT;
                            OP_LDCS: st_r <= S_SEND;
                            OP_BAD: st_r <= S_IDLE;
                            default: st_r <= S_OPER;
                        endcase
                    end
                S_OPER:
                    if (exc)
                        st_r <= S_ERR;
                    else if (rx_byte_p_r && left_r == ONE_OPERAND)
                        st_r <= S_IDLE;
                S_RDWAIT:
                    st_r <= exc ? S_ERR : S_SEND;
                S_SEND:
                    if (exc)
                        st_r <= S_ERR;
                    else if (tx_done_p_r)
                        st_r <= S_IDLE;
                S_ERR:
                    if (rx_brk_p_r)
                        st_r <= S_IDLE;
                default:
                    st_r <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            op_r <= 8'h00;
            left_r <= 4'h0;
        end
        else if (take_op)
        begin
            op_r <= rx_dat;
            left_r <= (new_op == OP_KEY) ? KEY_BYTES : ONE_OPERAND;
        end
        else if (take_opnd)
            left_r <= left_r - 4'h1;
    end

    // Pointer register
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ptr_r <= PTR_RESET;
        else if (take_op && new_op == OP_LDI)
            ptr_r <= ptr_r + 16'h0001;
        else if (take_opnd && cur_op == OP_STI)
            ptr_r <= ptr_r + 16'h0001;
        else if (take_opnd && cur_op == OP_STPTR)
        begin
            if (op_r[0])
                ptr_r[15:8] <= rx_dat;
            else
                ptr_r[7:0] <= rx_dat;
        end
    end

    // Data and I/O space strobes
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            acc_rd <= 1'b0;
            acc_wr <= 1'b0;
            acc_io <= 1'b0;
            acc_addr <= 16'h0000;
            acc_wdata <= 8'h00;
        end
        else
        begin
            acc_rd <= 1'b0;
            acc_wr <= 1'b0;
            if (take_op && (new_op == OP_LD || new_op == OP_LDI))
            begin
                acc_rd <= 1'b1;
                acc_io <= 1'b0;
                acc_addr <= ptr_r;
            end
            else if (take_op && new_op == OP_IN)
            begin
                acc_rd <= 1'b1;
                acc_io <= 1'b1;
                acc_addr <= spal_io_addr(rx_dat);
            end
            else if (take_opnd && (cur_op == OP_ST || cur_op == OP_STI))
            begin
                acc_wr <= 1'b1;
                acc_io <= 1'b0;
                acc_addr <= ptr_r;
                acc_wdata <= rx_dat;
            end
            else if (take_opnd && cur_op == OP_OUT)
            begin
                acc_wr <= 1'b1;
                acc_io <= 1'b1;
                acc_addr <= spal_io_addr(op_r);
                acc_wdata <= rx_dat;
            end
        end
    end

    always_comb
    begin
        case (rx_dat[3:0])
            CSS_STATUS: css_q = 8'(nvm_r) << NVM_BIT;
            CSS_PHYCTL: css_q = {5'h00, gt_r};
            CSS_IDENT: css_q = IDENT;
            default: css_q = 8'h00;
        endcase
    end

    // Reply byte handed to the transmitter
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            tx_go_r <= 1'b0;
            tx_dat_r <= 8'h00;
        end
        else
        begin
            tx_go_r <= 1'b0;
            if (st_r == S_RDWAIT && !exc)
            begin
                tx_go_r <= 1'b1;
                tx_dat_r <= acc_rdata;
            end
            else if (take_op && new_op == OP_LDCS)
            begin
                tx_go_r <= 1'b1;
                tx_dat_r <= css_q;
            end
        end
    end

    // Key shifts in first byte lowest
    assign key_nxt = {rx_dat, key_r[63:8]};

    // Control space registers and key check
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            gt_r <= GT_RESET;
            nvm_r <= 1'b0;
            key_r <= 64'h0;
        end
        else if (take_opnd)
        begin
            if (cur_op == OP_STCS && op_r[3:0] == CSS_PHYCTL)
                gt_r <= rx_dat[2:0];
            // Software may only clear the enable
            if (cur_op == OP_STCS && op_r[3:0] == CSS_STATUS && !rx_dat[NVM_BIT])
                nvm_r <= 1'b0;
            if (cur_op == OP_KEY)
            begin
                key_r <= key_nxt;
                if (left_r == ONE_OPERAND && key_nxt == UNLOCK_KEY)
                    nvm_r <= 1'b1;
            end
        end
    end

    assign nvm_enable = nvm_r;
endmodule

// ### logic/spal_host.sv
// Programmer end of the serial programming link: makes the link clock, sends
// characters and breaks, and collects one reply byte when asked to.
`timescale 1ns/1ps
module spal_host #(
    parameter int unsigned HALF_DIV = 8,
    parameter int unsigned WAIT_BITS = 200
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link
    spal_link_if.host lnk,
    // Command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_read,
    input wire logic cmd_break,
    // Reply port
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_err
);
    import spal_pkg::*;

    typedef enum {H_IDLE, H_SEND, H_WAIT, H_RECV} spal_hst_e;

    localparam logic [3:0] SEQ_LEN = 4'he;
    // Twelve low bits between idle bits
    localparam logic [13:0] BRK_SEQ = 14'h2001;

    spal_hst_e st_r;
    logic [15:0] div_r;
    logic lclk_r;
    logic tick;
    logic rise;
    logic fall;
    logic [1:0] dat_s_r;
    logic din;
    logic [13:0] sh_r;
    logic [15:0] cnt_r;
    logic rd_r;
    logic out_r;
    logic oe_r;
    logic [10:0] rsh_r;
    logic [10:0] rfull;

    // Link clock divided from the reference clock
    assign tick = (div_r == 16'(HALF_DIV - 1));
    // Send on falling, sample on rising
    assign rise = tick & ~lclk_r;
    assign fall = tick & lclk_r;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            div_r <= 16'h0000;
            lclk_r <= 1'b0;
        end
        else
        begin
            div_r <= tick ? 16'h0000 : div_r + 16'h0001;
            if (tick)
                lclk_r <= ~lclk_r;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            dat_s_r <= 2'h3;
        else
            dat_s_r <= {dat_s_r[0], lnk.line};
    end

    assign din = dat_s_r[1];
    assign rfull = {din, rsh_r[10:1]};
    assign cmd_ready = (st_r == H_IDLE);
    assign lnk.link_clk = lclk_r;
    assign lnk.host_o = out_r;
    assign lnk.host_oe = oe_r;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_r <= H_IDLE;
            sh_r <= 14'h3fff;
            cnt_r <= 16'h0000;
            rd_r <= 1'b0;
            out_r <= 1'b1;
            oe_r <= 1'b0;
            rsh_r <= 11'h7ff;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_err <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            case (st_r)
                H_IDLE:
                    if (cmd_valid)
                    begin
                        // Idle, start, data, parity, stops, idle
                        // A break is sent as its own command
                        sh_r <= cmd_break ? BRK_SEQ :
                            {3'b111, spal_parity(cmd_byte), cmd_byte, 2'b01};
                        rd_r <= cmd_read & ~cmd_break;
                        cnt_r <= 16'h0000;
                        st_r <= H_SEND;
                    end
                H_SEND:
                    if (fall)
                    begin
                        if (cnt_r[3:0] == SEQ_LEN)
                        begin
                            oe_r <= 1'b0;
                            out_r <= 1'b1;
                            cnt_r <= 16'h0000;
                            st_r <= rd_r ? H_WAIT : H_IDLE;
                        end
                        else
                        begin
                            out_r <= sh_r[0];
                            oe_r <= 1'b1;
                            sh_r <= {1'b1, sh_r[13:1]};
                            cnt_r <= cnt_r + 16'h0001;
                        end
                    end
                H_WAIT:
                    // Wait for the reply start bit, bounded
                    if (rise)
                    begin
                        if (!din)
                        begin
                            cnt_r <= 16'h0000;
                            st_r <= H_RECV;
                        end
                        else if (cnt_r == 16'(WAIT_BITS))
                        begin
                            rsp_valid <= 1'b1;
                            rsp_err <= 1'b1;
                            st_r <= H_IDLE;
                        end
                        else
                            cnt_r <= cnt_r + 16'h0001;
                    end
                H_RECV:
                    if (rise)
                    begin
                        rsh_r <= rfull;
                        cnt_r <= cnt_r + 16'h0001;
                        if (cnt_r[3:0] == RX_LAST)
                        begin
                            rsp_valid <= 1'b1;
                            rsp_data <= rfull[7:0];
                            rsp_err <= (rfull[10:9] != 2'b11) ||
                                (spal_parity(rfull[7:0]) != rfull[8]);
                            st_r <= H_IDLE;
                        end
                    end
                default:
                    st_r <= H_IDLE;
            endcase
        end
    end
endmodule

// ### dv/spal_link_sva.sv
// Link checker: line ownership and edge timing on the shared link.
// Takes the link signals as plain inputs; placed beside the link in the bench.
`timescale 1ns/1ps
module spal_link_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link
    input wire logic link_clk,
    input wire logic host_o,
    input wire logic host_oe,
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic line
);
    logic [4:0] gap_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Idle time on the line, saturating
    always_ff @(posedge ref_clk)
        if (sys_rst || host_oe || dev_oe)
            gap_r <= 5'h0;
        else if (gap_r != 5'h1f)
            gap_r <= gap_r + 5'h1;
    a_half_period: assert property ($rose(link_clk) |-> link_clk[*8] ##1 !link_clk)
        else $error("link clock half period wrong");
    a_host_fall_only: assert property ($changed({host_o, host_oe}) |-> !link_clk)
        else $error("host data moved with clock high");
    a_dev_fall_only: assert property ($changed({dev_o, dev_oe}) |-> !link_clk)
        else $error("device data moved with clock high");
    a_one_driver: assert property (!(host_oe && dev_oe))
        else $error("both ends drive the line");
    a_dev_start_low: assert property ($rose(dev_oe) |-> !dev_o)
        else $error("device frame without low start");
    a_host_idle_lead: assert property ($rose(host_oe) |-> host_o)
        else $error("host frame without idle lead");
    a_dev_high_once: assert property (dev_oe && $rose(dev_o) |-> ##[1:17] !(dev_oe && dev_o))
        else $error("device kept driving a high");
    a_turn_gap: assert property ($rose(dev_oe) |-> gap_r >= 5'h0c)
        else $error("device reply without idle gap");
endmodule

// ### dv/serial_prog_access_layer_bench.sv
// Bench: programmer end and device end joined by the link, driven by commands.
// Data and I/O space answer only in the read strobe cycle, from address and space.
`timescale 1ns/1ps
module serial_prog_access_layer_bench;
    import spal_pkg::*;
    localparam logic [63:0] KEY = 64'h0123_4567_89ab_cdef;
    logic ref_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic cmd_valid = 1'h0;
    logic cmd_read = 1'h0;
    logic cmd_break = 1'h0;
    logic [7:0] cmd_byte = 8'h0;
    logic [7:0] acc_rdata = 8'h0;
    logic [7:0] wr_n = 8'h0;
    logic cmd_ready, rsp_valid, rsp_err, acc_rd, acc_wr, acc_io, wr_io, nvm_enable;
    logic [7:0] rsp_data, acc_wdata, wr_data, n;
    logic [15:0] acc_addr, wr_addr;
    logic [31:0] r;
    int n_errors = 0;
    int comparisons = 0;
    // Opcode, operand, flags (read, store, I/O), expected byte; guard rows first, then pointer rows, then I/O and identity rows
    logic [31:0] rows [13] = '{32'h82000100, 32'hc2070000, 32'h82000107, 32'h68340000,
        32'h69120000, 32'h60a50234, 32'h645b0234, 32'h2400011b, 32'h20000118,
        32'h20000118, 32'hbf77061f, 32'h7f0001fc, 32'h8f00015a};
    spal_link_if lk();
    spal_host spal_host_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .lnk(lk),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_byte(cmd_byte),
        .cmd_read(cmd_read), .cmd_break(cmd_break), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_err(rsp_err));
    spal_device #(.UNLOCK_KEY(KEY)) spal_device_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .lnk(lk), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_io(acc_io), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .nvm_enable(nvm_enable));
    spal_link_sva spal_link_sva_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .link_clk(lk.link_clk), .host_o(lk.host_o), .host_oe(lk.host_oe),
        .dev_o(lk.dev_o), .dev_oe(lk.dev_oe), .line(lk.line));
    always #2.5 ref_clk = ~ref_clk;
    // Without a strobe the answer is zero, so a missing read strobe shows up
    always @(negedge ref_clk)
        acc_rdata <= (acc_rd === 1'h1) ? acc_addr[7:0] ^ acc_addr[15:8] ^ (acc_io ? 8'hc3 : 8'h3c)
            : 8'h00;
    always @(posedge ref_clk)
        if (acc_wr === 1'h1)
        begin
            wr_n <= wr_n + 8'h1;
            wr_addr <= acc_addr;
            wr_data <= acc_wdata;
            wr_io <= acc_io;
        end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One character; returns once the port is idle again
    task automatic send(input logic [7:0] b, input logic rd, input logic brk);
        int k;
        cmd_byte = b;
        cmd_read = rd;
        cmd_break = brk;
        cmd_valid = 1'h1;
        @(negedge ref_clk);
        cmd_valid = 1'h0;
        for (k = 0; k < 9000 && cmd_ready !== 1'h1; k++)
            @(negedge ref_clk);
        if (k == 9000)
        begin
            n_errors++;
            test_done();
        end
    endtask
    initial
    begin
        repeat (20) @(negedge ref_clk);
        sys_rst = 1'h0;
        for (int i = 0; i < 13; i++)
        begin
            r = rows[i];
            n = wr_n;
            send(r[31:24], r[8], 1'h0);
            if (r[8])
                chk({7'h0, rsp_valid, rsp_err, 7'h0, rsp_data}, {7'h0, 1'h1, 8'h0, r[7:0]});
            else
                send(r[23:16], 1'h0, 1'h0);
            chk({8'h0, wr_n - n, 7'h0, wr_io & r[9]}, {15'h0, r[9], 7'h0, r[10]});
            if (r[9])
                chk({wr_addr, wr_data}, {r[10] ? 8'h00 : 8'h12, r[7:0], r[23:16]});
        end
        // Key bytes go least significant first
        send(OPC_KEY, 1'h0, 1'h0);
        for (int i = 0; i < 8; i++)
            send(KEY[8 * i +: 8], 1'h0, 1'h0);
        send(8'h80, 1'h1, 1'h0);
        chk({7'h0, nvm_enable, 8'h0, rsp_data}, 24'h010002);
        // Writing zero to the status enable bit locks again
        send(8'hc0, 1'h0, 1'h0);
        send(8'h00, 1'h0, 1'h0);
        chk({23'h0, nvm_enable}, 24'h0);
        // A second reset restores the guard code
        sys_rst = 1'h1;
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'h0;
        send(8'h82, 1'h1, 1'h0);
        chk({7'h0, nvm_enable, 8'h0, rsp_data}, 24'h0);
        // Error state swallows a store and a read
        send(8'h00, 1'h0, 1'h1);
        n = wr_n;
        send(8'h60, 1'h0, 1'h0);
        send(8'h11, 1'h0, 1'h0);
        send(8'h8f, 1'h1, 1'h0);
        chk({wr_n - n, 7'h0, rsp_err, 8'h0}, 24'h000100);
        send(8'h00, 1'h0, 1'h1);
        send(8'h8f, 1'h1, 1'h0);
        chk({7'h0, rsp_err, rsp_data, 8'h0}, 24'h005a00);
        test_done();
    end
endmodule
